// ---- src/sixteen_line_port_pkg.sv ----
package sixteen_line_port_pkg;

   // ****************************************************************
   // register map
   // ****************************************************************
   // printed offsets are not all multiples of four, so each is kept as
   // an index and the byte address is four times the index
   localparam int ADDR_W = 18;
   localparam int DATA_W = 32;
   localparam int HALF_W = 8;
   localparam int NREG = 12;

   localparam int R_LAT_LO = 0;
   localparam int R_LAT_HI = 1;
   localparam int R_DIR_LO = 2;
   localparam int R_DIR_HI = 3;
   localparam int R_OD_HI = 4;
   localparam int R_SEL_LO = 5;
   localparam int R_SEL_HI = 6;
   localparam int R_PEN_LO = 7;
   localparam int R_PEN_HI = 8;
   localparam int R_HLD_LO = 9;
   localparam int R_HLD_HI = 10;
   localparam int R_LEVELS = 11;

   localparam logic [15:0] REG_IDX [NREG] = '{
      16'hFF00, 16'hFF02, 16'hF100, 16'hF102, 16'hFE22, 16'hFE60,
      16'hFE62, 16'hFE64, 16'hFE66, 16'hFE68, 16'hFE6A, 16'hFE6C};

   localparam logic [7:0] LATCH_RST = 8'h00;
   localparam logic [7:0] DIR_RST = 8'h00;
   localparam logic [7:0] OD_RST = 8'h00;
   localparam logic [7:0] PULL_RST = 8'hFF;
   localparam logic [7:0] HOLD_RST = 8'h00;

   localparam logic [7:0] REG_RST [NREG] = '{
      LATCH_RST, LATCH_RST, DIR_RST, DIR_RST, OD_RST, PULL_RST,
      PULL_RST, PULL_RST, PULL_RST, HOLD_RST, HOLD_RST, 8'h00};

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   function automatic logic [ADDR_W-1:0] reg_byte_addr(input int i);
      reg_byte_addr = {REG_IDX[i], 2'h0};
   endfunction : reg_byte_addr

endpackage : sixteen_line_port_pkg

// ---- src/half_cfg_if.sv ----
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// register file settings, with the alternate, bus and power-down inputs, handed to one 8-line half
// ****************************************************************
interface half_cfg_if;
   logic [7:0] latch;
   logic [7:0] dir;
   logic [7:0] od;
   logic [7:0] pull_en;
   logic [7:0] pull_sel;
   logic [7:0] hold;
   logic [7:0] alt_sel;
   logic [7:0] alt_data;
   logic [7:0] bus_data;
   logic bus_en;
   logic bus_drive;
   logic power_down;

   modport ctl (output latch, dir, od, pull_en, pull_sel, hold, alt_sel,
      alt_data, bus_data, bus_en, bus_drive, power_down);
   modport half (input latch, dir, od, pull_en, pull_sel, hold, alt_sel,
      alt_data, bus_data, bus_en, bus_drive, power_down);
endinterface : half_cfg_if

`default_nettype wire

// ---- src/ctl_reg8.sv ----
`timescale 1ns/10ps
`default_nettype none

module ctl_reg8 #(
   parameter logic [7:0] RST = 8'h00
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic we,
   input wire logic [7:0] d,
   output logic [7:0] q
);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= RST;
      end else if (we) begin
         q <= d;
      end
   end
endmodule : ctl_reg8

`default_nettype wire

// ---- src/port_half.sv ----
`timescale 1ns/10ps
`default_nettype none

module port_half
   import sixteen_line_port_pkg::*;
#(
   parameter bit OPEN_DRAIN = 1'b0
) (
   input wire logic aclk,
   input wire logic aresetn,
   half_cfg_if.half cfg,
   input wire logic [7:0] pin_in,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe,
   output logic [7:0] pull_en,
   output logic [7:0] pull_up,
   output logic [7:0] alt_in,
   output logic [7:0] level
);

   logic [7:0] drv;
   logic [7:0] val;
   logic [7:0] od;
   logic [7:0] oe_nxt;
   logic [7:0] out_nxt;

   for (genvar i = 0; i < 8; i++) begin : g_bit
      // the bus controller owns the direction while it is active
      assign drv[i] = cfg.bus_en ? cfg.bus_drive : cfg.dir[i];
      assign val[i] = cfg.bus_en ? cfg.bus_data[i] :
         (cfg.latch[i] & (cfg.alt_sel[i] ? cfg.alt_data[i] : 1'b1));
      assign od[i] = OPEN_DRAIN & cfg.od[i] & ~cfg.bus_en;
      // open drain only pulls low; a one leaves the line floating
      assign oe_nxt[i] = drv[i] & (~cfg.power_down | cfg.hold[i]) &
         (~od[i] | ~val[i]);
      assign out_nxt[i] = od[i] ? 1'b0 : val[i];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_oe <= DIR_RST;
         pin_out <= 8'h00;
      end else begin
         pin_oe <= oe_nxt;
         pin_out <= out_nxt;
      end
   end

   // pulls only on lines that are not driven, also in power-down
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pull_en <= PULL_RST;
         pull_up <= PULL_RST;
      end else begin
         pull_en <= cfg.pull_en & ~drv;
         pull_up <= cfg.pull_sel;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         level <= 8'h00;
         alt_in <= 8'h00;
      end else begin
         level <= pin_in;
         alt_in <= (drv & cfg.latch) | (~drv & pin_in);
      end
   end
endmodule : port_half

`default_nettype wire

// ---- src/sixteen_line_port_io_control.sv ----
// What this block does
// - alternate output reaches pin only when its direction bit says output.
// - pin value is output latch ANDed with alternate output data.
// - alternate input sees the pin on input, the latch on output.
// - after reset every direction bit selects input, lines undriven.
// - multiplexed bus mode switches direction in hardware, ignoring bits.
// - two 8-bit halves, each written without touching the other.
// - one direction bit per line; zero input, one output.
// - each upper line selectable push/pull or open drain.
// - enabled pull device connects to input lines, also in power-down.
// - pull-select bit chooses pulldown or pullup for each pin.
// - output lines never have their pull devices connected.
// - power-down turns output drivers off unless hold bit is one.
// - reset sets all pull-enable and pull-select bits high.
// - pull-select zero means pulldown, one means pullup.
// - open-drain bit zero push/pull, one open drain; resets zero.
// - read gives pin level on inputs, latch on outputs.
// - every pin level is sampled into its input latch each cycle.
`timescale 1ns/10ps
`default_nettype none

module sixteen_line_port_io_control
   import sixteen_line_port_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   // ****************************************************************
   // AXI4-Lite slave
   // ****************************************************************
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // ****************************************************************
   // pads
   // ****************************************************************
   input wire logic [15:0] pin_in,
   output logic [15:0] pin_out,
   output logic [15:0] pin_oe,
   output logic [15:0] pull_en,
   output logic [15:0] pull_up,
   // ****************************************************************
   // alternate functions and external bus controller
   // ****************************************************************
   input wire logic [15:0] alt_out_sel,
   input wire logic [15:0] alt_out_data,
   output logic [15:0] alt_in,
   input wire logic ext_bus_en_lo,
   input wire logic ext_bus_en_hi,
   input wire logic ext_bus_drive,
   input wire logic [15:0] ext_bus_out,
   input wire logic power_down
);

   // ********************
   // build checks
   // ********************
   // the register file and both halves are wired for 8-line halves
   if (HALF_W != 8 || DATA_W != 32) begin : g_bad_build
      $error("unsupported half or data width");
   end

   // ****************************************************************
   // write channel
   // ****************************************************************
   logic aw_rdy_r;
   logic w_rdy_r;
   logic aw_have_r;
   logic w_have_r;
   logic [ADDR_W-1:0] awaddr_r;
   logic [DATA_W-1:0] wdata_r;
   logic [3:0] wstrb_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic write_go;

   // address and data may arrive in either order; the write happens once
   // both are held, so a lone channel never stalls the other
   assign write_go = aw_have_r & w_have_r & ~bvalid_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_rdy_r <= 1'b1;
         aw_have_r <= 1'b0;
         awaddr_r <= '0;
      end else if (s_axi_awvalid && aw_rdy_r) begin
         aw_rdy_r <= 1'b0;
         aw_have_r <= 1'b1;
         awaddr_r <= s_axi_awaddr;
      end else if (write_go) begin
         aw_have_r <= 1'b0;
      end else if (bvalid_r && s_axi_bready) begin
         aw_rdy_r <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_rdy_r <= 1'b1;
         w_have_r <= 1'b0;
         wdata_r <= '0;
         wstrb_r <= 4'h0;
      end else if (s_axi_wvalid && w_rdy_r) begin
         w_rdy_r <= 1'b0;
         w_have_r <= 1'b1;
         wdata_r <= s_axi_wdata;
         wstrb_r <= s_axi_wstrb;
      end else if (write_go) begin
         w_have_r <= 1'b0;
      end else if (bvalid_r && s_axi_bready) begin
         w_rdy_r <= 1'b1;
      end
   end

   // ****************************************************************
   // write decode
   // ****************************************************************
   logic [NREG-1:0] wr_hit;
   logic [NREG-1:0] reg_we;

   for (genvar i = 0; i < NREG; i++) begin : g_wdec
      assign wr_hit[i] = (awaddr_r == reg_byte_addr(i));
      // each half is its own register, so a write never spills over
      assign reg_we[i] = write_go & wr_hit[i] & wstrb_r[0] &
         (i != R_LEVELS);
   end

   // ********************
   // write response
   // ********************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end else if (write_go) begin
         bvalid_r <= 1'b1;
         bresp_r <= (|wr_hit) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // ********************
   // write channel outputs
   // ********************
   assign s_axi_awready = aw_rdy_r;
   assign s_axi_wready = w_rdy_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;

   // ****************************************************************
   // register file
   // ****************************************************************
   logic [7:0] reg_q [NREG];

   for (genvar i = 0; i < NREG - 1; i++) begin : g_reg
      ctl_reg8 #(
         .RST(REG_RST[i])
      ) u_reg (
         .aclk(aclk),
         .aresetn(aresetn),
         .we(reg_we[i]),
         .d(wdata_r[7:0]),
         .q(reg_q[i])
      );
   end
   assign reg_q[R_LEVELS] = 8'h00;

   // ****************************************************************
   // the two halves
   // ****************************************************************
   half_cfg_if cfg_lo ();
   half_cfg_if cfg_hi ();
   logic [15:0] level;

   assign cfg_lo.latch = reg_q[R_LAT_LO];
   assign cfg_lo.dir = reg_q[R_DIR_LO];
   // the lower half has no open-drain option
   assign cfg_lo.od = OD_RST;
   assign cfg_lo.pull_en = reg_q[R_PEN_LO];
   assign cfg_lo.pull_sel = reg_q[R_SEL_LO];
   assign cfg_lo.hold = reg_q[R_HLD_LO];
   assign cfg_lo.alt_sel = alt_out_sel[7:0];
   assign cfg_lo.alt_data = alt_out_data[7:0];
   assign cfg_lo.bus_data = ext_bus_out[7:0];
   assign cfg_lo.bus_en = ext_bus_en_lo;
   assign cfg_lo.bus_drive = ext_bus_drive;
   assign cfg_lo.power_down = power_down;

   // ********************
   // upper half settings
   // ********************
   assign cfg_hi.latch = reg_q[R_LAT_HI];
   assign cfg_hi.dir = reg_q[R_DIR_HI];
   assign cfg_hi.od = reg_q[R_OD_HI];
   assign cfg_hi.pull_en = reg_q[R_PEN_HI];
   assign cfg_hi.pull_sel = reg_q[R_SEL_HI];
   assign cfg_hi.hold = reg_q[R_HLD_HI];
   assign cfg_hi.alt_sel = alt_out_sel[15:8];
   assign cfg_hi.alt_data = alt_out_data[15:8];
   assign cfg_hi.bus_data = ext_bus_out[15:8];
   // an 8-bit bus leaves the upper half free for general use
   assign cfg_hi.bus_en = ext_bus_en_hi;
   assign cfg_hi.bus_drive = ext_bus_drive;
   assign cfg_hi.power_down = power_down;

   // ********************
   // half instances
   // ********************
   port_half #(
      .OPEN_DRAIN(1'b0)
   ) u_lo (
      .aclk(aclk),
      .aresetn(aresetn),
      .cfg(cfg_lo.half),
      .pin_in(pin_in[7:0]),
      .pin_out(pin_out[7:0]),
      .pin_oe(pin_oe[7:0]),
      .pull_en(pull_en[7:0]),
      .pull_up(pull_up[7:0]),
      .alt_in(alt_in[7:0]),
      .level(level[7:0])
   );

   port_half #(
      .OPEN_DRAIN(1'b1)
   ) u_hi (
      .aclk(aclk),
      .aresetn(aresetn),
      .cfg(cfg_hi.half),
      .pin_in(pin_in[15:8]),
      .pin_out(pin_out[15:8]),
      .pin_oe(pin_oe[15:8]),
      .pull_en(pull_en[15:8]),
      .pull_up(pull_up[15:8]),
      .alt_in(alt_in[15:8]),
      .level(level[15:8])
   );

   // ****************************************************************
   // read channel
   // ****************************************************************
   logic ar_rdy_r;
   logic rd_pend_r;
   logic [ADDR_W-1:0] araddr_r;
   logic rvalid_r;
   logic [DATA_W-1:0] rdata_r;
   logic [1:0] rresp_r;
   logic [DATA_W-1:0] rd_word;
   logic rd_hit;
   logic [7:0] lat_view_lo;
   logic [7:0] lat_view_hi;

   // ********************
   // data register view
   // ********************
   // data register reads show the pin on inputs and the latch on
   // outputs, so read-modify-write keeps output values intact
   assign lat_view_lo = (reg_q[R_DIR_LO] & reg_q[R_LAT_LO]) |
      (~reg_q[R_DIR_LO] & level[7:0]);
   assign lat_view_hi = (reg_q[R_DIR_HI] & reg_q[R_LAT_HI]) |
      (~reg_q[R_DIR_HI] & level[15:8]);

   // ********************
   // read decode
   // ********************
   always_comb begin
      rd_word = '0;
      rd_hit = 1'b0;
      for (int i = 0; i < NREG; i++) begin
         if (araddr_r == reg_byte_addr(i)) begin
            rd_hit = 1'b1;
            if (i == R_LAT_LO) begin
               rd_word = {24'h000000, lat_view_lo};
            end else if (i == R_LAT_HI) begin
               rd_word = {24'h000000, lat_view_hi};
            end else if (i == R_LEVELS) begin
               rd_word = {16'h0000, level};
            end else begin
               rd_word = {24'h000000, reg_q[i]};
            end
         end
      end
   end

   // ********************
   // read address
   // ********************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ar_rdy_r <= 1'b1;
         rd_pend_r <= 1'b0;
         araddr_r <= '0;
      end else if (s_axi_arvalid && ar_rdy_r) begin
         ar_rdy_r <= 1'b0;
         rd_pend_r <= 1'b1;
         araddr_r <= s_axi_araddr;
      end else if (rd_pend_r) begin
         rd_pend_r <= 1'b0;
      end else if (rvalid_r && s_axi_rready) begin
         ar_rdy_r <= 1'b1;
      end
   end

   // ********************
   // read response
   // ********************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= RESP_OKAY;
      end else if (rd_pend_r) begin
         rvalid_r <= 1'b1;
         rdata_r <= rd_word;
         rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // ********************
   // read channel outputs
   // ********************
   assign s_axi_arready = ar_rdy_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

endmodule : sixteen_line_port_io_control

`default_nettype wire

// ---- test/sixteen_line_port_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module sixteen_line_port_sva
   import sixteen_line_port_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [DATA_W-1:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [15:0] pin_in,
   input wire logic [15:0] pin_out,
   input wire logic [15:0] pin_oe,
   input wire logic [15:0] pull_en,
   input wire logic [15:0] pull_up,
   input wire logic [15:0] alt_in,
   input wire logic ext_bus_en_lo,
   input wire logic ext_bus_drive,
   input wire logic [15:0] ext_bus_out,
   input wire logic power_down
);
   wire logic [7:0] bus_lo = ext_bus_out[7:0];
   wire logic [7:0] pin_lo = pin_in[7:0];
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_rst_val;
      $rose(aresetn) |-> pin_oe == 16'h0000 && pull_en == 16'hFFFF
         && pull_up == 16'hFFFF;
   endproperty
   a_rst_val: assert property (p_rst_val)
      else $error("reset output levels wrong");
   property p_no_pull;
      (pull_en & pin_oe) == 16'h0000;
   endproperty
   a_no_pull: assert property (p_no_pull)
      else $error("pull connected on driven line");
   property p_bus_drv;
      $past(aresetn) && $past(ext_bus_en_lo) && $past(ext_bus_drive)
         && !$past(power_down) |-> pin_oe[7:0] == 8'hFF
         && pin_out[7:0] == $past(bus_lo);
   endproperty
   a_bus_drv: assert property (p_bus_drv)
      else $error("bus address phase not driven");
   property p_bus_rcv;
      $past(aresetn) && $past(ext_bus_en_lo) && !$past(ext_bus_drive)
         |-> pin_oe[7:0] == 8'h00 && alt_in[7:0] == $past(pin_lo);
   endproperty
   a_bus_rcv: assert property (p_bus_rcv)
      else $error("bus data phase not received");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold)
      else $error("write response dropped");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
         && $stable(s_axi_rresp);
   endproperty
   a_r_hold: assert property (p_r_hold)
      else $error("read data dropped");
   property p_wr_ans;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |-> ##2 s_axi_bvalid;
   endproperty
   a_wr_ans: assert property (p_wr_ans)
      else $error("write answer late");
   property p_rd_ans;
      s_axi_arvalid && s_axi_arready |=> !s_axi_arready ##1 s_axi_rvalid;
   endproperty
   a_rd_ans: assert property (p_rd_ans)
      else $error("read answer late");
   c_wr: cover property (s_axi_bvalid && s_axi_bready);
   c_rd: cover property (s_axi_rvalid && s_axi_rready);
   c_bus: cover property (ext_bus_en_lo && ext_bus_drive);
endmodule : sixteen_line_port_sva
bind sixteen_line_port_io_control sixteen_line_port_sva u_sva (.aclk, .aresetn, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in,
   .pin_out, .pin_oe, .pull_en, .pull_up, .alt_in, .ext_bus_en_lo,
   .ext_bus_drive, .ext_bus_out, .power_down);
`default_nettype wire

// ---- test/pad_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module pad_model (
   input wire logic aclk,
   input wire logic [15:0] pin_out,
   input wire logic [15:0] pin_oe,
   input wire logic [15:0] pull_en,
   input wire logic [15:0] pull_up,
   input wire logic [15:0] ext_en,
   input wire logic [15:0] ext_val,
   output logic [15:0] pin_in
);
   // an undriven, unpulled line wanders, so no stale level is seen
   logic [15:0] flt = 16'hA5A5;
   always_ff @(posedge aclk) begin
      flt <= ~flt;
   end
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
            pull_en[i] ? pull_up[i] : flt[i];
      end
   end
endmodule : pad_model
`default_nettype wire

// ---- test/sixteen_line_port_io_control_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module sixteen_line_port_io_control_tb;
   import sixteen_line_port_pkg::*;
   // ********
   // signals
   // ********
   logic aclk = '0;
   logic aresetn = '0;
   logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata;
   logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
   logic s_axi_arvalid = '0, s_axi_rready = '0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [15:0] pin_in, pin_out, pin_oe, pull_en, pull_up, alt_in;
   logic [15:0] alt_sel = '0, alt_data = '0, bus_out = '0;
   logic [15:0] ext_en = '0, ext_val = '0;
   logic bus_lo = '0, bus_hi = '0, bus_drv = '0, pdn = '0;
   int errors = 0;
   int checked = 0;
   int cycles = 0;
   always #12.5 aclk = ~aclk;
   sixteen_line_port_io_control u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out,
      .pin_oe, .pull_en, .pull_up, .alt_out_sel(alt_sel),
      .alt_out_data(alt_data), .alt_in, .ext_bus_en_lo(bus_lo),
      .ext_bus_en_hi(bus_hi), .ext_bus_drive(bus_drv), .ext_bus_out(bus_out),
      .power_down(pdn));
   pad_model u_pads (.aclk, .pin_out, .pin_oe, .pull_en, .pull_up, .ext_en,
      .ext_val, .pin_in);
   // ********
   // helpers
   // ********
   task report_and_stop;
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : report_and_stop
   task chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   function automatic logic [ADDR_W-1:0] ra(input int i);
      return {REG_IDX[i], 2'h0};
   endfunction : ra
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d,
      output logic [1:0] r);
      bit ad = 0;
      bit dd = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(ad && dd)) begin
         @(posedge aclk);
         if (!ad && s_axi_awready === 1'b1) begin
            ad = 1;
            s_axi_awvalid <= 1'b0;
         end
         if (!dd && s_axi_wready === 1'b1) begin
            dd = 1;
            s_axi_wvalid <= 1'b0;
         end
      end
      s_axi_bready <= 1'b1;
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d,
      output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
   task automatic w(input int i, input logic [7:0] d);
      logic [1:0] r;
      wr(ra(i), d, r);
      chk(r, RESP_OKAY);
   endtask : w
   task automatic rchk(input int i, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      rd(ra(i), d, r);
      chk(r, RESP_OKAY);
      chk(d, e);
   endtask : rchk
   // pad outputs lag a register write by one edge
   task st;
      repeat (3) @(posedge aclk);
   endtask : st
   // ********
   // scenarios
   // ********
   task t_reset;
      chk(pin_oe, 32'h0);
      chk(pull_en & pull_up, 32'hFFFF);
      // undriven lines come up pulled high, so data reads show ones
      rchk(R_LAT_LO, 32'hFF);
      rchk(R_LAT_HI, 32'hFF);
      rchk(R_LEVELS, 32'hFFFF);
      for (int i = R_DIR_LO; i < NREG - 1; i++) rchk(i, REG_RST[i]);
   endtask : t_reset
   task t_halves;
      w(R_LAT_LO, 8'hA5);
      w(R_LAT_HI, 8'h3C);
      w(R_LAT_LO, 8'h5A);
      rchk(R_LAT_HI, 32'hFF);
      chk(pin_out[15:8], 32'h3C);
      w(R_DIR_LO, 8'hFF);
      st;
      chk({pin_oe, pin_out[7:0]}, 24'h00FF5A);
      chk(pull_en, 32'hFF00);
      rchk(R_LAT_LO, 32'h5A);
   endtask : t_halves
   task t_alt;
      alt_sel <= 16'h00FF;
      alt_data <= 16'h000F;
      st;
      chk(pin_out[7:0], 32'h0A);
      chk(alt_in[7:0], 32'h5A);
      w(R_DIR_LO, 8'h00);
      ext_en <= 16'h00FF;
      ext_val <= 16'h0077;
      st;
      chk(pin_oe, 32'h0);
      chk(alt_in[7:0], 32'h77);
      rchk(R_LAT_LO, 32'h77);
      rchk(R_LEVELS, 32'hFF77);
      alt_sel <= '0;
      ext_en <= '0;
   endtask : t_alt
   task t_pull;
      w(R_SEL_LO, 8'h0F);
      w(R_PEN_LO, 8'hF0);
      st;
      chk(pull_up[7:0], 32'h0F);
      chk(pull_en[7:0], 32'hF0);
      pdn <= 1'b1;
      st;
      chk(pull_en[7:0], 32'hF0);
      pdn <= 1'b0;
   endtask : t_pull
   task t_power;
      w(R_LAT_HI, 8'hFF);
      w(R_HLD_HI, 8'h0F);
      w(R_DIR_HI, 8'hFF);
      pdn <= 1'b1;
      st;
      chk(pin_oe, 32'h0F00);
      pdn <= 1'b0;
      st;
      chk(pin_oe, 32'hFF00);
   endtask : t_power
   task t_od;
      w(R_OD_HI, 8'hFF);
      w(R_LAT_HI, 8'hF0);
      st;
      chk({pin_oe, pin_out[15:8]}, 24'h0F0000);
      w(R_OD_HI, 8'h0F);
      st;
      chk({pin_oe, pin_out[15:8]}, 24'hFF00F0);
      w(R_DIR_HI, 8'h00);
   endtask : t_od
   task t_bus;
      rchk(R_DIR_LO, 32'h0);
      rchk(R_DIR_HI, 32'h0);
      bus_lo <= 1'b1;
      bus_hi <= 1'b1;
      bus_drv <= 1'b1;
      bus_out <= 16'h1234;
      st;
      chk({pin_oe[7:0], pin_out[7:0]}, 32'hFF34);
      chk({pin_oe[15:8], pin_out[15:8]}, 32'hFF12);
      bus_drv <= 1'b0;
      ext_en <= 16'hFFFF;
      ext_val <= 16'h3CC3;
      st;
      chk({pin_oe[7:0], alt_in[7:0]}, 32'h00C3);
      chk({pin_oe[15:8], alt_in[15:8]}, 32'h003C);
      bus_lo <= 1'b0;
      bus_hi <= 1'b0;
      ext_en <= '0;
   endtask : t_bus
   task automatic t_bad;
      logic [31:0] d;
      logic [1:0] r;
      s_axi_araddr <= 18'h00000;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      // answer left waiting, so the slave must hold it
      repeat (2) @(posedge aclk);
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      chk(d, 32'h0);
      chk(r, RESP_SLVERR);
      wr(18'h00000, 8'h55, r);
      chk(r, RESP_SLVERR);
   endtask : t_bad
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         $display("unexpected at %0t: run hung", $time);
         report_and_stop;
      end
   end
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset;
      t_halves;
      t_alt;
      t_pull;
      t_power;
      t_od;
      t_bus;
      t_bad;
      report_and_stop;
   end
endmodule : sixteen_line_port_io_control_tb
`default_nettype wire
